// [hw/ucr_regbank.v]
`default_nettype none
`include "ucr_regs.vh"
// Contract
// - per-profile 8-bit gain scales samples before converter
// - gain is 1.7 fixed point, 0 to 1.9921875
// - rate field 01h bypasses interpolation filters
// - rate 02h to 3Fh interpolates by that value
// - tuning word bytes assembled low address first
// - documented reset values loaded on reset
// - profile-1 registers unreset; host writes before use
// - multiplier 01h bypass, 04h-14h multiply, else invalid
// - mode 0 quad, 1 tone, 2 interp, 3 invalid
module ucr_regbank (
    input  wire        REF_CLK,          // 100 MHz system clock
    input  wire        RST_N,            // synchronous, active low
    input  wire [4:0]  ADDR,             // register address
    input  wire [7:0]  WDATA,            // write data
    input  wire        WR_STB,           // write strobe
    input  wire        RD_STB,           // read strobe
    output reg  [7:0]  RDATA,            // read data, cycle after strobe
    input  wire [13:0] SAMPLE_IN,        // datapath sample, same clock
    input  wire        SAMPLE_VALID,     // sample strobe
    output wire [13:0] SCALED_OUT,       // scaled sample to converter
    output wire        SCALED_VALID,     // scaled sample strobe
    output reg  [31:0] TUNING_WORD,      // active profile tuning word
    output reg         PLL_BYPASS,       // multiplier bypassed
    output reg  [4:0]  PLL_MULT,         // valid multiplier, 1 if bypass
    output reg         MULT_INVALID,     // multiplier code invalid
    output reg         PLL_LOCK_IGNORE,  // ignore lock indicator
    output reg         LSB_FIRST,        // serial port lsb first
    output reg         DIO_INPUT_ONLY,   // serial data pin input only
    output reg         MODE_QUAD,        // quadrature modulation
    output reg         MODE_TONE,        // single tone
    output reg         MODE_INTERP,      // interpolating converter
    output reg         MODE_INVALID,     // mode code invalid
    output reg         AUTO_POWER_DOWN,  // automatic power down
    output reg         FULL_SLEEP,       // full shutdown
    output reg         INV_SINC_BYPASS,  // inverse sinc bypassed
    output reg         INTERP_FILT_CLEAR,// clear interpolation filters
    output reg         INV_COMP_BYPASS,  // inverse filter comp bypassed
    output reg         SPECTRAL_INVERT,  // add rather than subtract Q
    output reg         INTERP_BYPASS,    // interpolation filters bypassed
    output reg  [5:0]  INTERP_RATE,      // active rate, 1 if bypassed
    output reg         RATE_INVALID,     // rate code 00h
    output reg         INTERP_STROBE,    // one pulse per output period
    output reg         PROFILE_ACTIVE,   // selected profile, 0 or 1
    output reg         PROFILE1_READY    // all profile-1 bytes written
);
    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    reg  [7:0] clkcfg_reg;
    reg  [7:0] opcfg_reg;
    reg  [7:0] tw0_reg [0:3];
    reg  [7:0] filt0_reg;
    reg  [7:0] gain0_reg;
    reg  [7:0] tw1_reg [0:3];
    reg  [7:0] filt1_reg;
    reg  [7:0] gain1_reg;
    reg  [7:0] gain3_reg;
    reg        psel_reg;
    reg  [5:0] p1_written_reg;
    reg  [5:0] p1_written_next;
    reg  [5:0] rate_cnt_reg;
    reg  [5:0] rate_cnt_next;
    reg  [7:0] rdata_next;

    wire wr_clkcfg = WR_STB && (ADDR == `UCR_OFS_CLKCFG);
    wire wr_opcfg  = WR_STB && (ADDR == `UCR_OFS_OPCFG);
    wire wr_filt0  = WR_STB && (ADDR == `UCR_OFS_FILT0);
    wire wr_gain0  = WR_STB && (ADDR == `UCR_OFS_GAIN0);
    wire wr_filt1  = WR_STB && (ADDR == `UCR_OFS_FILT1);
    wire wr_gain1  = WR_STB && (ADDR == `UCR_OFS_GAIN1);
    wire wr_gain3  = WR_STB && (ADDR == `UCR_OFS_GAIN3);
    wire wr_psel   = WR_STB && (ADDR == `UCR_OFS_PSEL);
    wire wr_tw0    = WR_STB && (ADDR >= `UCR_OFS_TW0_B0) &&
                     (ADDR <= `UCR_OFS_TW0_B3);
    wire wr_tw1    = WR_STB && (ADDR >= `UCR_OFS_TW1_B0) &&
                     (ADDR <= `UCR_OFS_TW1_B3);
    wire [1:0] tw0_idx = ADDR[1:0] - 2'h2;   // 02h..05h -> 0..3
    wire [1:0] tw1_idx = ADDR[1:0];          // 08h..0Bh -> 0..3

    // ------------------------------------------------------------------
    // registers with a defined reset value
    // ------------------------------------------------------------------
    // tuning byte 0 of profile 0 has no reset value but shares the array
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            clkcfg_reg <= `UCR_RST_CLKCFG;
            opcfg_reg  <= `UCR_RST_OPCFG;
            tw0_reg[1] <= `UCR_RST_TW_HI;
            tw0_reg[2] <= `UCR_RST_TW_HI;
            tw0_reg[3] <= `UCR_RST_TW_HI;
            filt0_reg  <= `UCR_RST_FILT0;
            gain0_reg  <= `UCR_RST_GAIN0;
            psel_reg   <= (`UCR_RST_PSEL != 8'h00);
        end else begin
            if (wr_clkcfg)
                clkcfg_reg <= WDATA;
            // reserved bits are not stored and read back as zero
            if (wr_opcfg)
                opcfg_reg <= WDATA & `UCR_OPCFG_MASK;
            if (wr_tw0)
                tw0_reg[tw0_idx] <= WDATA;
            if (wr_filt0)
                filt0_reg <= WDATA;
            if (wr_gain0)
                gain0_reg <= WDATA;
            if (wr_psel)
                psel_reg <= WDATA[0];
        end
    end

    // ------------------------------------------------------------------
    // registers left unset by reset
    // ------------------------------------------------------------------
    // no reset branch here: the host must load them before use
    always @(posedge REF_CLK) begin
        // one process per array keeps a single driver on each memory
        // profile-0 byte 0 is written with its siblings in the reset block
        if (wr_tw1)
            tw1_reg[tw1_idx] <= WDATA;
        if (wr_filt1)
            filt1_reg <= WDATA;
        if (wr_gain1)
            gain1_reg <= WDATA;
        if (wr_gain3)
            gain3_reg <= WDATA;
    end

    // track which profile-1 bytes have been written since reset
    always @* begin
        p1_written_next = p1_written_reg;
        if (wr_tw1)
            p1_written_next[tw1_idx] = 1'b1;
        if (wr_filt1)
            p1_written_next[4] = 1'b1;
        if (wr_gain1)
            p1_written_next[5] = 1'b1;
    end

    always @(posedge REF_CLK) begin
        if (!RST_N)
            p1_written_reg <= 6'h00;
        else
            p1_written_reg <= p1_written_next;
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    // unmapped addresses read zero; data stands one cycle only
    always @* begin
        rdata_next = 8'h00;
        case (ADDR)
            `UCR_OFS_CLKCFG: rdata_next = clkcfg_reg;
            `UCR_OFS_OPCFG:  rdata_next = opcfg_reg;
            `UCR_OFS_TW0_B0: rdata_next = tw0_reg[0];
            `UCR_OFS_TW0_B1: rdata_next = tw0_reg[1];
            `UCR_OFS_TW0_B2: rdata_next = tw0_reg[2];
            `UCR_OFS_TW0_B3: rdata_next = tw0_reg[3];
            `UCR_OFS_FILT0:  rdata_next = filt0_reg;
            `UCR_OFS_GAIN0:  rdata_next = gain0_reg;
            `UCR_OFS_TW1_B0: rdata_next = tw1_reg[0];
            `UCR_OFS_TW1_B1: rdata_next = tw1_reg[1];
            `UCR_OFS_TW1_B2: rdata_next = tw1_reg[2];
            `UCR_OFS_TW1_B3: rdata_next = tw1_reg[3];
            `UCR_OFS_FILT1:  rdata_next = filt1_reg;
            `UCR_OFS_GAIN1:  rdata_next = gain1_reg;
            `UCR_OFS_GAIN3:  rdata_next = gain3_reg;
            `UCR_OFS_STATUS: rdata_next = {4'h0, RATE_INVALID,
                                           MODE_INVALID, MULT_INVALID,
                                           PROFILE1_READY};
            `UCR_OFS_PSEL:   rdata_next = {7'h00, psel_reg};
            default:         rdata_next = 8'h00;
        endcase
        if (!RD_STB)
            rdata_next = 8'h00;
    end

    always @(posedge REF_CLK) begin
        if (!RST_N)
            RDATA <= 8'h00;
        else
            RDATA <= rdata_next;
    end

    // ------------------------------------------------------------------
    // active profile fields
    // ------------------------------------------------------------------
    // profile 1 is used as programmed; reading an unset one is host error
    wire [7:0] filt_act = psel_reg ? filt1_reg : filt0_reg;
    wire [7:0] gain_act = psel_reg ? gain1_reg : gain0_reg;
    wire [5:0] rate_fld = filt_act[`UCR_RATE_MSB:`UCR_RATE_LSB];
    wire [4:0] mult_fld = clkcfg_reg[`UCR_MULT_MSB:`UCR_MULT_LSB];
    wire [1:0] mode_fld = opcfg_reg[`UCR_MODE_MSB:`UCR_MODE_LSB];
    wire       rate_bad = (rate_fld == `UCR_RATE_INVALID);
    wire       rate_byp = (rate_fld == `UCR_RATE_BYPASS);
    wire       mult_byp = (mult_fld == `UCR_MULT_BYPASS);
    wire       mult_ok  = (mult_fld >= `UCR_MULT_MIN) &&
                          (mult_fld <= `UCR_MULT_MAX);

    // lowest address is the lowest byte of the word
    wire [31:0] tw0_word = {tw0_reg[3], tw0_reg[2],
                            tw0_reg[1], tw0_reg[0]};
    wire [31:0] tw1_word = {tw1_reg[3], tw1_reg[2],
                            tw1_reg[1], tw1_reg[0]};

    // ------------------------------------------------------------------
    // registered control outputs
    // ------------------------------------------------------------------
    // decoded once per cycle so that downstream sees clean flop outputs
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            TUNING_WORD       <= 32'h00000000;
            PLL_BYPASS        <= 1'b0;
            PLL_MULT          <= 5'h01;
            MULT_INVALID      <= 1'b0;
            PLL_LOCK_IGNORE   <= 1'b0;
            LSB_FIRST         <= 1'b0;
            DIO_INPUT_ONLY    <= 1'b0;
            MODE_QUAD         <= 1'b0;
            MODE_TONE         <= 1'b0;
            MODE_INTERP       <= 1'b0;
            MODE_INVALID      <= 1'b0;
            AUTO_POWER_DOWN   <= 1'b0;
            FULL_SLEEP        <= 1'b0;
            INV_SINC_BYPASS   <= 1'b0;
            INTERP_FILT_CLEAR <= 1'b0;
            INV_COMP_BYPASS   <= 1'b0;
            SPECTRAL_INVERT   <= 1'b0;
            INTERP_BYPASS     <= 1'b0;
            INTERP_RATE       <= 6'h01;
            RATE_INVALID      <= 1'b0;
            PROFILE_ACTIVE    <= 1'b0;
            PROFILE1_READY    <= 1'b0;
        end else begin
            TUNING_WORD     <= psel_reg ? tw1_word : tw0_word;
            PLL_BYPASS      <= mult_byp;
            PLL_MULT        <= mult_ok ? mult_fld : 5'h01;
            MULT_INVALID    <= !mult_byp && !mult_ok;
            PLL_LOCK_IGNORE <= clkcfg_reg[`UCR_LOCK_IGN_BIT];
            LSB_FIRST       <= clkcfg_reg[`UCR_LSB_FIRST_BIT];
            DIO_INPUT_ONLY  <= clkcfg_reg[`UCR_DIO_IN_BIT];
            MODE_QUAD   <= (mode_fld == `UCR_MODE_QUAD);
            MODE_TONE   <= (mode_fld == `UCR_MODE_TONE);
            MODE_INTERP <= (mode_fld == `UCR_MODE_INTERP);
            MODE_INVALID <= (mode_fld == 2'h3);
            AUTO_POWER_DOWN   <= opcfg_reg[`UCR_AUTO_PD_BIT];
            FULL_SLEEP        <= opcfg_reg[`UCR_SLEEP_BIT];
            INV_SINC_BYPASS   <= opcfg_reg[`UCR_INV_SINC_BIT];
            INTERP_FILT_CLEAR <= opcfg_reg[`UCR_FILT_CLR_BIT];
            INV_COMP_BYPASS   <= filt_act[`UCR_INV_COMP_BIT];
            SPECTRAL_INVERT   <= filt_act[`UCR_SPEC_INV_BIT];
            INTERP_BYPASS     <= rate_byp;
            INTERP_RATE <= rate_bad ? 6'h01 : rate_fld;
            RATE_INVALID      <= rate_bad;
            PROFILE_ACTIVE    <= psel_reg;
            PROFILE1_READY    <= (p1_written_reg == `UCR_P1_ALL);
        end
    end

    // ------------------------------------------------------------------
    // interpolation period counter
    // ------------------------------------------------------------------
    // one strobe every rate cycles; bypass strobes each cycle; an invalid
    // rate stops the strobe rather than guess a period
    always @* begin
        if (rate_bad || rate_byp || INTERP_FILT_CLEAR)
            rate_cnt_next = 6'h00;
        else if (rate_cnt_reg >= rate_fld - 6'h01)
            rate_cnt_next = 6'h00;
        else
            rate_cnt_next = rate_cnt_reg + 6'h01;
    end

    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            rate_cnt_reg  <= 6'h00;
            INTERP_STROBE <= 1'b0;
        end else begin
            rate_cnt_reg  <= rate_cnt_next;
            INTERP_STROBE <= !rate_bad && !INTERP_FILT_CLEAR &&
                             (rate_cnt_reg == 6'h00);
        end
    end

    // ------------------------------------------------------------------
    // output scaler
    // ------------------------------------------------------------------
    ucr_scaler u_scaler (
        .clk        (REF_CLK),
        .rst_n      (RST_N),
        .sample     (SAMPLE_IN),
        .valid      (SAMPLE_VALID),
        .gain       (gain_act),
        .scaled     (SCALED_OUT),
        .scaled_vld (SCALED_VALID)
    );
endmodule // ucr_regbank
`default_nettype wire

// [hw/ucr_regs.vh]
`ifndef UCR_REGS_VH
`define UCR_REGS_VH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define UCR_ADDR_W        5
`define UCR_OFS_CLKCFG    5'h00
`define UCR_OFS_OPCFG     5'h01
`define UCR_OFS_TW0_B0    5'h02
`define UCR_OFS_TW0_B1    5'h03
`define UCR_OFS_TW0_B2    5'h04
`define UCR_OFS_TW0_B3    5'h05
`define UCR_OFS_FILT0     5'h06
`define UCR_OFS_GAIN0     5'h07
`define UCR_OFS_TW1_B0    5'h08
`define UCR_OFS_TW1_B1    5'h09
`define UCR_OFS_TW1_B2    5'h0A
`define UCR_OFS_TW1_B3    5'h0B
`define UCR_OFS_FILT1     5'h0C
`define UCR_OFS_GAIN1     5'h0D
`define UCR_OFS_GAIN3     5'h19
`define UCR_OFS_STATUS    5'h1E
`define UCR_OFS_PSEL      5'h1F
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define UCR_MULT_MSB      4
`define UCR_MULT_LSB      0
`define UCR_LOCK_IGN_BIT  5
`define UCR_LSB_FIRST_BIT 6
`define UCR_DIO_IN_BIT    7
`define UCR_MODE_MSB      1
`define UCR_MODE_LSB      0
`define UCR_AUTO_PD_BIT   2
`define UCR_SLEEP_BIT     3
`define UCR_INV_SINC_BIT  6
`define UCR_FILT_CLR_BIT  7
`define UCR_INV_COMP_BIT  0
`define UCR_SPEC_INV_BIT  1
`define UCR_RATE_MSB      7
`define UCR_RATE_LSB      2
`define UCR_GAIN_FRAC     7
// ----------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------
`define UCR_RST_CLKCFG    8'h21
`define UCR_RST_OPCFG     8'h00
`define UCR_RST_TW_HI     8'h00
`define UCR_RST_FILT0     8'h08
`define UCR_RST_GAIN0     8'hB5
`define UCR_RST_PSEL      8'h00
`define UCR_OPCFG_MASK    8'hCF
`define UCR_MULT_BYPASS   5'h01
`define UCR_MULT_MIN      5'h04
`define UCR_MULT_MAX      5'h14
`define UCR_MODE_QUAD     2'h0
`define UCR_MODE_TONE     2'h1
`define UCR_MODE_INTERP   2'h2
`define UCR_RATE_INVALID  6'h00
`define UCR_RATE_BYPASS   6'h01
`define UCR_P1_ALL        6'h3F
`endif

// [hw/ucr_scaler.v]
`default_nettype none
`include "ucr_regs.vh"
module ucr_scaler (
    input  wire               clk,        // system clock
    input  wire               rst_n,      // synchronous, active low
    input  wire signed [13:0] sample,     // datapath sample
    input  wire               valid,      // sample strobe
    input  wire        [7:0]  gain,       // unsigned 1.7 gain
    output reg  signed [13:0] scaled,     // scaled, saturated sample
    output reg                scaled_vld  // scaled sample strobe
);
    // ------------------------------------------------------------------
    // multiply and saturate
    // ------------------------------------------------------------------
    wire signed [8:0]  gain_s = {1'b0, gain};
    wire signed [22:0] prod   = sample * gain_s;
    // drop seven fraction bits: msb weighs one, lsb 2^-7
    wire signed [15:0] shifted = prod[22:`UCR_GAIN_FRAC];
    reg  signed [13:0] sat;

    // gain up to almost two can overflow the 14-bit range, so clamp
    always @* begin
        if (shifted > 16'sh1FFF)
            sat = 14'sh1FFF;
        else if (shifted < -16'sh2000)
            sat = 14'sh2000;
        else
            sat = shifted[13:0];
    end

    // output stage, one cycle after the input
    always @(posedge clk) begin
        if (!rst_n) begin
            scaled     <= 14'h0000;
            scaled_vld <= 1'b0;
        end else begin
            scaled     <= valid ? sat : scaled;
            scaled_vld <= valid;
        end
    end
endmodule // ucr_scaler
`default_nettype wire

// [test/tb.sv]
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, smp_vld, wr_stb, rd_stb, scl_vld, byp, minv, lck;
    logic mq, mt, mi, mdi, fclr, icb, sinv, ibyp, rinv, istb, pact, rdy;
    logic lsbf, dio, apd, slp, isb;
    logic [4:0] addr, mult;
    logic [7:0] wdata, rdata, rv;
    logic [13:0] smp, scl;
    logic [31:0] tw;
    logic [5:0] rate;
    int n_fail = 0;
    int check_count = 0;
    int n;
    logic [4:0] ra [7] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07};
    logic [7:0] rs [7] = '{8'h21, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'hB5};
    logic [4:0] mc [8] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h0A, 5'h14, 5'h15,
                           5'h1F};
    logic [5:0] rt [4] = '{6'h01, 6'h02, 6'h07, 6'h3F};
    logic [7:0] gn [4] = '{8'h80, 8'hFF, 8'h00, 8'hB5};
    logic [13:0] sv [4] = '{14'h03E8, 14'h2000, 14'h1FFF, 14'h3FFF};
    ucr_host host_u (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb));
    ucr_regbank dut_u (.REF_CLK(clk), .RST_N(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
        .SAMPLE_IN(smp), .SAMPLE_VALID(smp_vld), .SCALED_OUT(scl),
        .SCALED_VALID(scl_vld), .TUNING_WORD(tw), .PLL_BYPASS(byp),
        .PLL_MULT(mult), .MULT_INVALID(minv), .PLL_LOCK_IGNORE(lck),
        .LSB_FIRST(lsbf), .DIO_INPUT_ONLY(dio), .MODE_QUAD(mq),
        .MODE_TONE(mt), .MODE_INTERP(mi), .MODE_INVALID(mdi),
        .AUTO_POWER_DOWN(apd), .FULL_SLEEP(slp), .INV_SINC_BYPASS(isb),
        .INTERP_FILT_CLEAR(fclr),
        .INV_COMP_BYPASS(icb), .SPECTRAL_INVERT(sinv),
        .INTERP_BYPASS(ibyp), .INTERP_RATE(rate), .RATE_INVALID(rinv),
        .INTERP_STROBE(istb), .PROFILE_ACTIVE(pact), .PROFILE1_READY(rdy));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        host_u.rd(a, rv);
        chk(rv, e);
    endtask
    // write, then wait for the decoded outputs to follow
    task automatic wset(input logic [4:0] a, input logic [7:0] d);
        host_u.wr(a, d);
        repeat (2) @(posedge clk);
        #1;
    endtask
    // 126 is a multiple of every rate used, so the count is exact
    task automatic cnt_stb();
        n = 0;
        repeat (64) @(posedge clk);
        repeat (126) begin
            @(posedge clk);
            #1;
            if (istb === 1'b1) n++;
        end
    endtask
    task automatic samp(input logic [13:0] s, input logic [7:0] g);
        logic signed [22:0] p;
        p = $signed(s) * $signed({1'b0, g});
        p = p >>> 7;
        if (p > 8191) p = 8191;
        if (p < -8192) p = -8192;
        @(posedge clk);
        smp <= s;
        smp_vld <= 1'b1;
        @(posedge clk);
        smp_vld <= 1'b0;
        #1;
        chk(scl_vld, 1'b1);
        chk(scl, p[13:0]);
    endtask
    task automatic rst_chk();
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({byp, mq, lck, rate, rdy, pact}, {3'b111, 6'h02, 2'b00});
        for (int i = 0; i < 7; i++) rchk(ra[i], rs[i]);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
    initial begin
        rst_n = 1'b0;
        smp = 14'h0000;
        smp_vld = 1'b0;
        rst_chk();
        foreach (mc[i]) begin
            wset(5'h00, {3'b001, mc[i]});
            n = (mc[i] >= 5'h04 && mc[i] <= 5'h14);
            chk({byp, minv, mult}, {mc[i] == 5'h01, n == 0 && mc[i] != 5'h01,
                n ? mc[i] : 5'h01});
        end
        wset(5'h00, 8'hC1);
        chk({dio, lsbf, lck, byp}, 4'hD);
        for (int m = 0; m < 4; m++) begin
            wset(5'h01, 8'h10 | m[7:0]);
            chk({mdi, mi, mt, mq}, 4'h1 << m);
            rchk(5'h01, m[7:0]);
        end
        wset(5'h01, 8'hCC);
        chk({fclr, isb, slp, apd, mq}, 5'h1F);
        wset(5'h01, 8'h00);
        for (int b = 0; b < 4; b++) host_u.wr(5'h02 + b[4:0], 8'hA1 + b[7:0]);
        wset(5'h1F, 8'h00);
        chk(tw, 32'hA4A3A2A1);
        for (int b = 0; b < 6; b++) begin
            chk(rdy, 1'b0);
            wset(5'h08 + b[4:0], (b == 4) ? 8'h1F : 8'h3C + b[7:0]);
        end
        chk(rdy, 1'b1);
        rchk(5'h1E, 8'h01);
        wset(5'h1F, 8'h01);
        chk(tw, 32'h3F3E3D3C);
        chk({pact, rate, icb, sinv}, {1'b1, 6'h07, 2'b11});
        samp(14'h3F9C, 8'h41);
        wset(5'h1F, 8'h00);
        wset(5'h0F, 8'hAA);
        rchk(5'h0F, 8'h00);
        wset(5'h19, 8'h5A);
        rchk(5'h19, 8'h5A);
        foreach (rt[i]) begin
            wset(5'h06, {rt[i], 2'b00});
            chk({ibyp, rate, rinv}, {rt[i] == 6'h01, rt[i], 1'b0});
            cnt_stb();
            chk(n, 126 / rt[i]);
        end
        wset(5'h01, 8'h80);
        cnt_stb();
        chk(n, 0);
        wset(5'h01, 8'h00);
        foreach (gn[i]) begin
            wset(5'h07, gn[i]);
            samp(sv[i], gn[i]);
        end
        @(posedge clk);
        rst_chk();
        report_and_stop();
    end
endmodule // tb
bind ucr_regbank ucr_regbank_props chk_u (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB),
    .SAMPLE_VALID(SAMPLE_VALID), .SCALED_VALID(SCALED_VALID),
    .TUNING_WORD(TUNING_WORD), .PLL_BYPASS(PLL_BYPASS), .PLL_MULT(PLL_MULT),
    .MULT_INVALID(MULT_INVALID), .MODE_QUAD(MODE_QUAD),
    .MODE_TONE(MODE_TONE), .MODE_INTERP(MODE_INTERP),
    .MODE_INVALID(MODE_INVALID), .INTERP_BYPASS(INTERP_BYPASS),
    .INTERP_RATE(INTERP_RATE), .RATE_INVALID(RATE_INVALID),
    .INTERP_STROBE(INTERP_STROBE), .INTERP_FILT_CLEAR(INTERP_FILT_CLEAR),
    .PROFILE_ACTIVE(PROFILE_ACTIVE), .PROFILE1_READY(PROFILE1_READY));
`default_nettype wire

// [test/ucr_host.sv]
`default_nettype none
module ucr_host (
    input  wire logic       clk,    // system clock
    input  wire logic [7:0] rdata,  // read data
    output logic      [4:0] addr,   // address
    output logic      [7:0] wdata,  // write data
    output logic            wr_stb, // write strobe
    output logic            rd_stb  // read strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        addr = 5'h00;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end
    // idle bus shows inverted leftovers so stale values never match
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = (a == 5'h01) ? (d & 8'hDF) : d;
        if ((a == 5'h06 || a == 5'h0C) && v[7:2] == 6'h00) begin
            v[7:2] = 6'h01;
        end
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        addr <= ~a;
        wdata <= ~v;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        addr <= ~a;
        @(posedge clk);
        d = rdata;
    endtask
endmodule // ucr_host
`default_nettype wire

// [test/ucr_regbank_props.sv]
`default_nettype none
module ucr_regbank_props (
    input wire logic        REF_CLK,           // clock
    input wire logic        RST_N,             // reset
    input wire logic [4:0]  ADDR,              // address
    input wire logic [7:0]  WDATA,             // write data
    input wire logic        WR_STB,            // write strobe
    input wire logic        SAMPLE_VALID,      // sample in
    input wire logic        SCALED_VALID,      // sample out
    input wire logic [31:0] TUNING_WORD,       // tuning word
    input wire logic        PLL_BYPASS,        // bypass
    input wire logic [4:0]  PLL_MULT,          // multiplier
    input wire logic        MULT_INVALID,      // bad multiplier
    input wire logic        MODE_QUAD,         // mode flags
    input wire logic        MODE_TONE,         // mode flags
    input wire logic        MODE_INTERP,       // mode flags
    input wire logic        MODE_INVALID,      // mode flags
    input wire logic        INTERP_BYPASS,     // rate bypass
    input wire logic [5:0]  INTERP_RATE,       // rate
    input wire logic        RATE_INVALID,      // bad rate
    input wire logic        INTERP_STROBE,     // rate strobe
    input wire logic        INTERP_FILT_CLEAR, // filter clear
    input wire logic        PROFILE_ACTIVE,    // profile
    input wire logic        PROFILE1_READY     // profile-1 ready
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    property p_mult; WR_STB && ADDR == 5'h00 && WDATA[4:0] == 5'h01 |->
        ##2 PLL_BYPASS && PLL_MULT == 5'h01 && !MULT_INVALID; endproperty
    a_mult: assert property (p_mult) else $error("bypass code");
    property p_mrng; $past(RST_N) && !MULT_INVALID && !PLL_BYPASS |->
        PLL_MULT >= 5'h04 && PLL_MULT <= 5'h14; endproperty
    a_mrng: assert property (p_mrng) else $error("mult range");
    property p_mode; WR_STB && ADDR == 5'h01 |-> ##2
        {MODE_INVALID, MODE_INTERP, MODE_TONE, MODE_QUAD}
        == (4'h1 << $past(WDATA[1:0], 2)); endproperty
    a_mode: assert property (p_mode) else $error("mode decode");
    property p_byp; INTERP_BYPASS |-> INTERP_RATE == 6'h01 && !RATE_INVALID;
    endproperty
    a_byp: assert property (p_byp) else $error("bypass rate");
    property p_rate2; INTERP_STROBE && !INTERP_FILT_CLEAR &&
        INTERP_RATE == 6'h02 && $past(INTERP_RATE) == 6'h02 &&
        $past(INTERP_RATE, 2) == 6'h02 |=> !INTERP_STROBE; endproperty
    a_rate2: assert property (p_rate2) else $error("rate 2 gap");
    property p_tw; WR_STB && ADDR == 5'h03 ##1 !PROFILE_ACTIVE |=>
        TUNING_WORD[15:8] == $past(WDATA, 2); endproperty
    a_tw: assert property (p_tw) else $error("tuning byte 1");
    property p_rst; $rose(RST_N) |=> PLL_BYPASS && MODE_QUAD &&
        INTERP_RATE == 6'h02 && TUNING_WORD[31:8] == 24'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset decode");
    property p_rdy; PROFILE1_READY |=> PROFILE1_READY; endproperty
    a_rdy: assert property (p_rdy) else $error("ready dropped");
    property p_svld; $past(RST_N) |-> SCALED_VALID == $past(SAMPLE_VALID);
    endproperty
    a_svld: assert property (p_svld) else $error("scaled strobe");
endmodule // ucr_regbank_props
`default_nettype wire
